// [bench/ilc_chk.sv]
// Concurrent checks on the interrupt level controller ports
`timescale 1ns/1ps
module ilc_chk
   import ilc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // CPU core side
   input wire logic insn_boundary,
   input wire logic ctx_save_ack,
   input wire logic ctx_save_req,
   input wire logic vector_fetch,
   input wire logic [ADDR_W-1:0] vector_addr,
   input wire logic [LVL_W-1:0] level_mask,
   input wire logic int_enable,
   input wire logic pend_valid,
   input wire logic [LVL_W-1:0] pend_level,
   // Transfer-service engine side
   input wire logic svc_done,
   input wire logic [STS_W-1:0] svc_status,
   input wire logic svc_start,
   input wire logic [ADDR_W-1:0] svc_desc_addr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic in_svc_ff, nxt_in_svc;
   // Tracks a running transfer service, ended only by its done pulse
   always_comb begin
      nxt_in_svc = in_svc_ff;
      if (svc_start) nxt_in_svc = 1'b1;
      else if (svc_done) nxt_in_svc = 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) in_svc_ff <= 1'b0;
      else in_svc_ff <= nxt_in_svc;
   end
   // Save handshake, then a single fetch cycle
   sequence s_ack; ctx_save_req && ctx_save_ack; endsequence
   sequence s_fetch; !ctx_save_req && vector_fetch ##1 !vector_fetch; endsequence
   property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
   a_apb: assert property (p_apb) else $error("pready not a single access cycle");
   property p_gate;
      svc_start || ($rose(ctx_save_req) && !$past(svc_done)) |-> $past(int_enable) && $past(insn_boundary);
   endproperty
   a_gate: assert property (p_gate) else $error("accepted while disabled");
   property p_save; s_ack |=> s_fetch; endproperty
   a_save: assert property (p_save) else $error("no fetch after save");
   property p_vec; vector_fetch |-> vector_addr >= VEC_BASE && vector_addr <= VEC_TOP && vector_addr[1:0] == 2'h0;
   endproperty
   a_vec: assert property (p_vec) else $error("vector outside table");
   property p_mask; vector_fetch |-> level_mask != LVL_NONE; endproperty
   a_mask: assert property (p_mask) else $error("mask loaded with level seven");
   property p_desc;
      svc_start |-> svc_desc_addr[2:0] == 3'h0 && svc_desc_addr >= DESC_BASE && svc_desc_addr <= DESC_BASE + 24'h78;
   endproperty
   a_desc: assert property (p_desc) else $error("descriptor address off");
   property p_start; svc_start |=> !svc_start; endproperty
   a_start: assert property (p_start) else $error("start not a pulse");
   property p_one; in_svc_ff |-> !svc_start && !ctx_save_req; endproperty
   a_one: assert property (p_one) else $error("accepted during service");
   property p_done; svc_done && in_svc_ff |=> ctx_save_req == ($past(svc_status) != SVC_RUNNING); endproperty
   a_done: assert property (p_done) else $error("wrong action at service end");
   property p_pend; pend_valid |-> pend_level != LVL_NONE; endproperty
   a_pend: assert property (p_pend) else $error("level seven pending");
endmodule
bind ilc_top ilc_chk i_ilc_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .insn_boundary(insn_boundary), .ctx_save_ack(ctx_save_ack), .ctx_save_req(ctx_save_req),
   .vector_fetch(vector_fetch), .vector_addr(vector_addr), .level_mask(level_mask),
   .int_enable(int_enable), .pend_valid(pend_valid), .pend_level(pend_level),
   .svc_done(svc_done), .svc_status(svc_status), .svc_start(svc_start), .svc_desc_addr(svc_desc_addr)
);

// [bench/ilc_cpu_model.sv]
// Behavioural CPU core that answers context save requests
`timescale 1ns/1ps
module ilc_cpu_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pace set by the bench
   input wire logic slow,
   // Acceptance handshake
   input wire logic ctx_save_req,
   output logic ctx_save_ack,
   output logic insn_boundary
);
   logic [2:0] wait_ff, nxt_wait;
   logic tog_ff;
   // Stack push time counted from the request
   always_comb begin
      nxt_wait = wait_ff;
      if (!ctx_save_req) nxt_wait = 3'h0;
      else if (wait_ff != 3'h7) nxt_wait = wait_ff + 3'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_ff <= 3'h0;
         tog_ff <= 1'b0;
      end else begin
         wait_ff <= nxt_wait;
         tog_ff <= ~tog_ff;
      end
   end
   // Ack at once or after four cycles, only while asked
   assign ctx_save_ack = ctx_save_req && (wait_ff >= (slow ? 3'h4 : 3'h0));
   // Slow pace ends an instruction only every other cycle
   assign insn_boundary = !slow || tog_ff;
endmodule

// [bench/ilc_top_test.sv]
// Self-checking bench of the interrupt level controller
`timescale 1ns/1ps
module ilc_top_test;
   import ilc_pkg::*;
   // Stimulus and observed ports
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, svc_done = 1'b0, slow = 1'b0;
   logic [PADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [NSRC-1:0] req_flag = 16'h0, req_enable = 16'h0;
   logic [STS_W-1:0] svc_status = 2'h0;
   logic pready, pslverr, insn_boundary, ctx_save_ack, ctx_save_req, vector_fetch, int_enable, pend_valid, svc_start;
   logic [ADDR_W-1:0] vector_addr, svc_desc_addr;
   logic [LVL_W-1:0] level_mask, pend_level;
   int failures = 0, tests_run = 0, cyc = 0;
   logic err;
   ilc_top i_ilc_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_flag(req_flag), .req_enable(req_enable), .insn_boundary(insn_boundary),
      .ctx_save_ack(ctx_save_ack), .ctx_save_req(ctx_save_req), .vector_fetch(vector_fetch),
      .vector_addr(vector_addr), .level_mask(level_mask), .int_enable(int_enable),
      .pend_valid(pend_valid), .pend_level(pend_level), .svc_done(svc_done),
      .svc_status(svc_status), .svc_start(svc_start), .svc_desc_addr(svc_desc_addr)
   );
   ilc_cpu_model i_ilc_cpu_model (
      .pclk(pclk), .presetn(presetn), .slow(slow), .ctx_save_req(ctx_save_req),
      .ctx_save_ack(ctx_save_ack), .insn_boundary(insn_boundary)
   );
   initial forever #12.5 pclk = ~pclk;
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Hang guard, far above the run's few hundred cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; idle cycle first so strobes never change twice at once
   task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Waits as long as the slave likes; only the hang guard ends it
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Slave promises its answer in the first access cycle
      chk(32'(n), 32'h1);
   endtask
   task automatic rchk(input logic [PADDR_W-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Bounded wait for a fetch or a service start pulse
   task automatic wt(input bit svc);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((svc ? svc_start : vector_fetch) !== 1'b1 && n < 60);
      chk(32'(n < 60), 32'h1);
   endtask
   task automatic accept(input int src, input logic [LVL_W-1:0] lv);
      wt(1'b0);
      chk(32'(vector_addr), 32'(VEC_BASE + ADDR_W'(4 * src)));
      chk(32'(level_mask), 32'(lv));
   endtask
   // No context save request or vector fetch may appear for a dozen cycles
   task automatic quiet;
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         @(posedge pclk);
         seen = seen | ctx_save_req | vector_fetch;
      end
      chk(32'(seen), 32'h0);
   endtask
   task automatic done(input logic [STS_W-1:0] st);
      @(posedge pclk);
      svc_done <= 1'b1;
      svc_status <= st;
      @(posedge pclk);
      svc_done <= 1'b0;
   endtask
   task automatic t_reset;
      for (int i = 0; i < NSRC; i++) begin
         rchk(OFS_SRC_BASE + 12'(4 * i), 32'h0000_0007);
      end
      rchk(OFS_CPU_CTRL, 32'h0000_0000);
      apb(1'b0, 12'h080, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0000_0000);
      apb(1'b1, 12'h00C, 32'h0000_00FD);
      rchk(12'h00C, 32'h0000_000D);
   endtask
   task automatic t_prio;
      apb(1'b1, 12'h008, 32'h0000_0002);
      apb(1'b1, 12'h014, 32'h0000_0002);
      apb(1'b1, 12'h024, 32'h0000_0001);
      req_flag <= 16'h0224;
      req_enable <= 16'h0024;
      apb(1'b1, OFS_CPU_CTRL, 32'h0000_0103);
      accept(2, 3'h2);
      chk(32'(int_enable), 32'h1);
      slow <= 1'b1;
      req_enable <= 16'h0224;
      accept(9, 3'h1);
      req_flag <= 16'h0024;
      apb(1'b1, OFS_CPU_CTRL, 32'h0000_0007);
      quiet();
      chk(32'(pend_level), 32'h2);
      chk(32'(pend_valid), 32'h1);
      chk(32'(int_enable), 32'h0);
      // Pending level 2, valid, last source 9, sequencer idle
      rchk(OFS_STATUS, 32'h0000_009A);
      apb(1'b1, OFS_CPU_CTRL, 32'h0000_0102);
      quiet();
      apb(1'b1, OFS_CPU_CTRL, 32'h0000_0103);
      accept(2, 3'h2);
      req_flag <= 16'h0000;
      slow <= 1'b0;
   endtask
   // Service on channel 15, re-armed by a running status, then ended
   task automatic t_svc;
      logic [STS_W-1:0] st;
      // Source 3 needs its enable bit as well as its flag
      req_enable <= 16'h022C;
      for (int k = 0; k < 2; k++) begin
         st = k ? SVC_PERIPH_STOP : SVC_COUNT_END;
         slow <= 1'(k);
         apb(1'b1, 12'h00C, 32'h0000_00FD);
         apb(1'b1, OFS_CPU_CTRL, 32'h0000_0107);
         req_flag <= 16'h0008;
         wt(1'b1);
         chk(32'(svc_desc_addr), 32'h0000_0178);
         done(SVC_RUNNING);
         wt(1'b1);
         req_flag <= 16'h000C;
         done(st);
         accept(3, 3'h5);
         accept(2, 3'h2);
         req_flag <= 16'h0000;
         rchk(12'h00C, {24'h0, st, 6'h05});
      end
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_prio();
      t_svc();
      stop_test();
   end
endmodule

// [core/ilc_arb_if.sv]
// Carrier between the controller top and its priority arbiter
`timescale 1ns/1ps
interface ilc_arb_if;
   import ilc_pkg::*;
   logic [NSRC-1:0] req;
   logic [LVL_W-1:0] lvl [NSRC];
   logic win_valid;
   logic [SRC_W-1:0] win_idx;
   logic [LVL_W-1:0] win_lvl;
   modport arb (input req, input lvl, output win_valid, output win_idx, output win_lvl);
   modport ctl (output req, output lvl, input win_valid, input win_idx, input win_lvl);
endinterface

// [core/ilc_arbiter.sv]
// Combinational priority arbiter over all live requests
`timescale 1ns/1ps
module ilc_arbiter
   import ilc_pkg::*;
(
   // Requests in, winner out
   ilc_arb_if.arb arb
);

   // Smallest level wins; scanning downward with <= lets the lowest index take ties
   always_comb begin
      arb.win_valid = 1'b0;
      arb.win_idx = '0;
      arb.win_lvl = LVL_NONE;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (arb.req[i] && (!arb.win_valid || arb.lvl[i] <= arb.win_lvl)) begin
            arb.win_valid = 1'b1;
            arb.win_idx = SRC_W'(i);
            arb.win_lvl = arb.lvl[i];
         end
      end
   end

endmodule

// [core/ilc_pkg.sv]
// Constants, field layout and types of the interrupt level controller
package ilc_pkg;
   // Structure
   localparam int NSRC = 16;
   localparam int SRC_W = 4;
   localparam int LVL_W = 3;
   localparam int CH_W = 4;
   localparam int STS_W = 2;
   localparam int ADDR_W = 24;
   localparam int PADDR_W = 12;

   // Level encodings
   localparam logic [LVL_W-1:0] LVL_NONE = 3'h7;

   // Source control register fields (8 bits, low lanes of the word)
   localparam int LVL_LSB = 0;
   localparam int ARM_BIT = 3;
   localparam int CH_LSB = 4;
   localparam int STS_LSB = 6;

   // CPU control register fields
   localparam int MASK_LSB = 0;
   localparam int GIE_BIT = 8;

   // Reset values
   localparam logic [LVL_W-1:0] RST_LVL = 3'h7;
   localparam logic RST_ARM = 1'b0;
   localparam logic [CH_W-1:0] RST_CH = 4'h0;
   localparam logic [STS_W-1:0] RST_STS = 2'h0;
   localparam logic [LVL_W-1:0] RST_MASK = 3'h0;
   localparam logic RST_GIE = 1'b0;

   // Transfer-service completion codes
   localparam logic [STS_W-1:0] SVC_RUNNING = 2'h0;
   localparam logic [STS_W-1:0] SVC_COUNT_END = 2'h1;
   localparam logic [STS_W-1:0] SVC_RESERVED = 2'h2;
   localparam logic [STS_W-1:0] SVC_PERIPH_STOP = 2'h3;

   // Register byte offsets
   localparam logic [PADDR_W-1:0] OFS_SRC_BASE = 12'h000;
   localparam logic [PADDR_W-1:0] OFS_SRC_LAST = 12'h03C;
   localparam logic [PADDR_W-1:0] OFS_CPU_CTRL = 12'h040;
   localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h044;

   // Memory map of descriptors and vectors
   localparam logic [ADDR_W-1:0] DESC_BASE = 24'h000100;
   localparam logic [ADDR_W-1:0] VEC_BASE = 24'hFFFF00;
   localparam logic [ADDR_W-1:0] VEC_TOP = 24'hFFFFF0;

   // Acceptance sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SERVICE = 2'b01,
      ST_SAVE = 2'b10
   } ilc_state_t;
endpackage

// [core/ilc_top.sv]
// Interrupt level controller: source control registers, arbitration and acceptance
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ilc_top
   import ilc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral requests
   input wire logic [NSRC-1:0] req_flag,
   input wire logic [NSRC-1:0] req_enable,
   // CPU core side
   input wire logic insn_boundary,
   input wire logic ctx_save_ack,
   output logic ctx_save_req,
   output logic vector_fetch,
   output logic [ADDR_W-1:0] vector_addr,
   output logic [LVL_W-1:0] level_mask,
   output logic int_enable,
   output logic pend_valid,
   output logic [LVL_W-1:0] pend_level,
   // Transfer-service engine side
   input wire logic svc_done,
   input wire logic [STS_W-1:0] svc_status,
   output logic svc_start,
   output logic [ADDR_W-1:0] svc_desc_addr
);

   // Hit flag for a word-aligned source control address, then its register index
   function automatic logic src_hit(input logic [PADDR_W-1:0] a);
      src_hit = (a >= OFS_SRC_BASE) && (a <= OFS_SRC_LAST) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [SRC_W-1:0] src_sel(input logic [PADDR_W-1:0] a);
      logic [PADDR_W-1:0] d;
      d = a - OFS_SRC_BASE;
      src_sel = d[SRC_W+1:2];
   endfunction

   // Control register state
   logic [LVL_W-1:0] lvl_ff [NSRC];
   logic [LVL_W-1:0] nxt_lvl [NSRC];
   logic [NSRC-1:0] arm_ff;
   logic [NSRC-1:0] nxt_arm;
   logic [CH_W-1:0] ch_ff [NSRC];
   logic [CH_W-1:0] nxt_ch [NSRC];
   logic [STS_W-1:0] sts_ff [NSRC];
   logic [STS_W-1:0] nxt_sts [NSRC];
   logic [LVL_W-1:0] mask_ff;
   logic [LVL_W-1:0] nxt_mask;
   logic gie_ff;
   logic nxt_gie;

   // Bus state
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pready_ff;
   logic nxt_pready;
   logic pslverr_ff;
   logic nxt_pslverr;

   // Sequencer state
   ilc_state_t state_ff;
   ilc_state_t nxt_state;
   logic [SRC_W-1:0] cur_src_ff;
   logic [SRC_W-1:0] nxt_cur_src;
   logic [LVL_W-1:0] cur_lvl_ff;
   logic [LVL_W-1:0] nxt_cur_lvl;
   logic ctx_req_ff;
   logic nxt_ctx_req;
   logic vec_ff;
   logic nxt_vec;
   logic [ADDR_W-1:0] vec_addr_ff;
   logic [ADDR_W-1:0] nxt_vec_addr;
   logic svc_start_ff;
   logic nxt_svc_start;
   logic [ADDR_W-1:0] desc_ff;
   logic [ADDR_W-1:0] nxt_desc;
   logic pend_valid_ff;
   logic [LVL_W-1:0] pend_lvl_ff;

   // Decoded strobes
   logic wr_en;
   logic accept;
   logic svc_end;
   logic svc_stop;

   ilc_arb_if arb_bus ();

   // Live requests; level 7 never competes
   generate
      for (genvar g = 0; g < NSRC; g++) begin : g_req
         assign arb_bus.req[g] = req_flag[g] & req_enable[g] & (lvl_ff[g] != LVL_NONE);
         assign arb_bus.lvl[g] = lvl_ff[g];
      end
   endgenerate

   ilc_arbiter u_arb (
      .arb(arb_bus)
   );

   // Write lands only at the completing access edge
   assign wr_en = psel & penable & pready_ff & pwrite;

   // Acceptance needs idle sequencer, enable, level below mask, instruction boundary
   assign accept = (state_ff == ST_IDLE) && arb_bus.win_valid && gie_ff &&
                   (arb_bus.win_lvl < mask_ff) && insn_boundary;

   assign svc_end = (state_ff == ST_SERVICE) && svc_done;
   assign svc_stop = svc_end && (svc_status != SVC_RUNNING);

   // Control registers: software writes, hardware completion updates
   always_comb begin
      nxt_mask = mask_ff;
      nxt_gie = gie_ff;
      for (int i = 0; i < NSRC; i++) begin
         nxt_lvl[i] = lvl_ff[i];
         nxt_arm[i] = arm_ff[i];
         nxt_ch[i] = ch_ff[i];
         nxt_sts[i] = sts_ff[i];
      end
      if (wr_en && src_hit(paddr)) begin
         nxt_lvl[src_sel(paddr)] = pwdata[LVL_LSB +: LVL_W];
         nxt_arm[src_sel(paddr)] = pwdata[ARM_BIT];
         nxt_ch[src_sel(paddr)] = pwdata[CH_LSB +: CH_W];
         // Arming restarts status at "not started"
         if (pwdata[ARM_BIT]) begin
            nxt_sts[src_sel(paddr)] = SVC_RUNNING;
         end
      end
      if (wr_en && (paddr == OFS_CPU_CTRL)) begin
         nxt_mask = pwdata[MASK_LSB +: LVL_W];
         nxt_gie = pwdata[GIE_BIT];
      end
      // Hardware completion wins over a same-cycle software write
      if (svc_end) begin
         nxt_sts[cur_src_ff] = svc_status;
      end
      if (svc_stop) begin
         nxt_arm[cur_src_ff] = 1'b0;
      end
      // Mask takes the accepted level once the context is safe
      if ((state_ff == ST_SAVE) && ctx_save_ack) begin
         nxt_mask = cur_lvl_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NSRC; i++) begin
            lvl_ff[i] <= RST_LVL;
            ch_ff[i] <= RST_CH;
            sts_ff[i] <= RST_STS;
         end
         arm_ff <= {NSRC{RST_ARM}};
         mask_ff <= RST_MASK;
         gie_ff <= RST_GIE;
      end else begin
         for (int i = 0; i < NSRC; i++) begin
            lvl_ff[i] <= nxt_lvl[i];
            ch_ff[i] <= nxt_ch[i];
            sts_ff[i] <= nxt_sts[i];
         end
         arm_ff <= nxt_arm;
         mask_ff <= nxt_mask;
         gie_ff <= nxt_gie;
      end
   end

   // APB: zero wait states, data prepared in the setup cycle
   always_comb begin
      nxt_pready = psel & ~penable;
      nxt_pslverr = 1'b0;
      nxt_prdata = prdata_ff;
      if (psel && !penable) begin
         nxt_prdata = '0;
         if (src_hit(paddr)) begin
            // Read view shows status where the channel was written
            nxt_prdata[STS_LSB +: STS_W] = sts_ff[src_sel(paddr)];
            nxt_prdata[ARM_BIT] = arm_ff[src_sel(paddr)];
            nxt_prdata[LVL_LSB +: LVL_W] = lvl_ff[src_sel(paddr)];
         end else if (paddr == OFS_CPU_CTRL) begin
            nxt_prdata[MASK_LSB +: LVL_W] = mask_ff;
            nxt_prdata[GIE_BIT] = gie_ff;
         end else if (paddr == OFS_STATUS) begin
            nxt_prdata[2:0] = pend_lvl_ff;
            nxt_prdata[3] = pend_valid_ff;
            nxt_prdata[7:4] = cur_src_ff;
            nxt_prdata[9:8] = state_ff;
         end else begin
            nxt_pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Acceptance sequencer; other requests wait while not idle
   always_comb begin
      nxt_state = state_ff;
      nxt_cur_src = cur_src_ff;
      nxt_cur_lvl = cur_lvl_ff;
      nxt_ctx_req = ctx_req_ff;
      nxt_vec = 1'b0;
      nxt_vec_addr = vec_addr_ff;
      nxt_svc_start = 1'b0;
      nxt_desc = desc_ff;
      case (state_ff)
         ST_IDLE: begin
            if (accept) begin
               nxt_cur_src = arb_bus.win_idx;
               nxt_cur_lvl = arb_bus.win_lvl;
               if (arm_ff[arb_bus.win_idx]) begin
                  nxt_svc_start = 1'b1;
                  nxt_desc = DESC_BASE + {17'h00000, ch_ff[arb_bus.win_idx], 3'h0};
                  nxt_state = ST_SERVICE;
               end else begin
                  nxt_ctx_req = 1'b1;
                  nxt_state = ST_SAVE;
               end
            end
         end
         ST_SERVICE: begin
            // One transfer unit done; a stop code hands over to normal handling
            if (svc_done) begin
               if (svc_status != SVC_RUNNING) begin
                  nxt_ctx_req = 1'b1;
                  nxt_state = ST_SAVE;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_SAVE: begin
            if (ctx_save_ack) begin
               nxt_ctx_req = 1'b0;
               nxt_vec = 1'b1;
               nxt_vec_addr = VEC_BASE + {18'h00000, cur_src_ff, 2'h0};
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_ctx_req = 1'b0;
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         cur_src_ff <= '0;
         cur_lvl_ff <= LVL_NONE;
         ctx_req_ff <= 1'b0;
         vec_ff <= 1'b0;
         vec_addr_ff <= VEC_BASE;
         svc_start_ff <= 1'b0;
         desc_ff <= DESC_BASE;
         pend_valid_ff <= 1'b0;
         pend_lvl_ff <= LVL_NONE;
      end else begin
         state_ff <= nxt_state;
         cur_src_ff <= nxt_cur_src;
         cur_lvl_ff <= nxt_cur_lvl;
         ctx_req_ff <= nxt_ctx_req;
         vec_ff <= nxt_vec;
         vec_addr_ff <= nxt_vec_addr;
         svc_start_ff <= nxt_svc_start;
         desc_ff <= nxt_desc;
         // Winner registered every cycle so withdrawals show at the next edge
         pend_valid_ff <= arb_bus.win_valid;
         pend_lvl_ff <= arb_bus.win_lvl;
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign ctx_save_req = ctx_req_ff;
   assign vector_fetch = vec_ff;
   assign vector_addr = vec_addr_ff;
   assign level_mask = mask_ff;
   assign int_enable = gie_ff;
   assign pend_valid = pend_valid_ff;
   assign pend_level = pend_lvl_ff;
   assign svc_start = svc_start_ff;
   assign svc_desc_addr = desc_ff;

endmodule
